// >>> logic/rdpg_cfg.svh
`ifndef RDPG_CFG_SVH
`define RDPG_CFG_SVH

// Register offsets
`define RDPG_OFS_DISCH2 8'h41
`define RDPG_OFS_DISCH3 8'h42
`define RDPG_OFS_PGDLY 8'h43

// Field layout
`define RDPG_FLD_W 2
`define RDPG_DISCH2_RAILS 4
`define RDPG_NUM_RAILS 7
`define RDPG_DLY_W 3
`define RDPG_DISCH3_PAD 2'h0
`define RDPG_PGDLY_PAD 5'h00

// Reset values
`define RDPG_SEL_RST 2'h0
`define RDPG_DLY_RST 3'h0
`define RDPG_RDATA_RST 8'h00
`define RDPG_UNMAPPED 8'h00

// Timing: clock rate and delay figures in microseconds
`define RDPG_CLK_MHZ 100
`define RDPG_DLY0_US 2500
`define RDPG_DLY1_US 5000
`define RDPG_DLY2_US 10000
`define RDPG_DLY3_US 15000
`define RDPG_DLY4_US 20000
`define RDPG_DLY5_US 50000
`define RDPG_DLY6_US 75000
`define RDPG_DLY7_US 100000
`define RDPG_CNT_W 24
`define RDPG_CNT_ONE 24'h000001
`endif

// >>> logic/rdpg_delay_timer.sv
`include "rdpg_cfg.svh"

module rdpg_delay_timer
   import rdpg_pkg::*;
#(
   parameter int CNT_W = `RDPG_CNT_W
)
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // Control
   input wire logic start_i,
   input wire logic [CNT_W-1:0] limit_i,
   // Result
   output logic done_o
);
   rdpg_tmr_state_t state_reg;
   rdpg_tmr_state_t state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   wire logic expired = cnt_reg >= limit_i;
   wire logic [CNT_W-1:0] cnt_inc = cnt_reg + CNT_W'(1);

   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      unique case (state_reg)
         TMR_IDLE:
         begin
            cnt_next = CNT_W'(1);
            if (start_i)
               state_next = TMR_COUNT;
         end
         TMR_COUNT:
         begin
            // Dropping the trigger restarts the whole delay, never resumes it
            if (!start_i)
               state_next = TMR_IDLE;
            else if (expired)
               state_next = TMR_DONE;
            else
               cnt_next = cnt_inc;
         end
         TMR_DONE:
         begin
            if (!start_i)
               state_next = TMR_IDLE;
         end
         default:
         begin
            state_next = TMR_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         state_reg <= TMR_IDLE;
         cnt_reg <= CNT_W'(1);
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   assign done_o = state_reg == TMR_DONE;
endmodule

// >>> logic/rdpg_pkg.sv
package rdpg_pkg;
   typedef enum logic [1:0]
   {
      DISCH_NONE = 2'h0,
      DISCH_R100 = 2'h1,
      DISCH_R200 = 2'h2,
      DISCH_R500 = 2'h3
   } rdpg_disch_t;

   typedef enum logic [1:0]
   {
      OUT3_POWER_GOOD = 2'h0,
      OUT3_LEVEL_SHIFT = 2'h1,
      OUT3_HOST = 2'h2
   } rdpg_out3_mode_t;

   typedef enum logic [2:0]
   {
      TMR_IDLE = 3'b001,
      TMR_COUNT = 3'b010,
      TMR_DONE = 3'b100
   } rdpg_tmr_state_t;
endpackage

// >>> logic/rdpg_regs.sv
`include "rdpg_cfg.svh"

module rdpg_regs
   import rdpg_pkg::*;
#(
   parameter int NUM_RAILS = `RDPG_NUM_RAILS,
   parameter int CNT_W = `RDPG_CNT_W,
   // Every delay is a whole multiple of the shortest, so one unit scales the whole table
   parameter int DLY_UNIT_CYC = `RDPG_DLY0_US * `RDPG_CLK_MHZ,
   parameter int DLY0_CYC = DLY_UNIT_CYC,
   parameter int DLY1_CYC = DLY_UNIT_CYC * (`RDPG_DLY1_US / `RDPG_DLY0_US),
   parameter int DLY2_CYC = DLY_UNIT_CYC * (`RDPG_DLY2_US / `RDPG_DLY0_US),
   parameter int DLY3_CYC = DLY_UNIT_CYC * (`RDPG_DLY3_US / `RDPG_DLY0_US),
   parameter int DLY4_CYC = DLY_UNIT_CYC * (`RDPG_DLY4_US / `RDPG_DLY0_US),
   parameter int DLY5_CYC = DLY_UNIT_CYC * (`RDPG_DLY5_US / `RDPG_DLY0_US),
   parameter int DLY6_CYC = DLY_UNIT_CYC * (`RDPG_DLY6_US / `RDPG_DLY0_US),
   parameter int DLY7_CYC = DLY_UNIT_CYC * (`RDPG_DLY7_US / `RDPG_DLY0_US)
)
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // Register port
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // Rail state
   input wire logic [NUM_RAILS-1:0] rail_enable_i,
   input wire logic [NUM_RAILS-1:0] rail_in_reg_i,
   // Discharge selection per rail, one-hot over resistance
   output logic [NUM_RAILS-1:0] disch_ohm100_o,
   output logic [NUM_RAILS-1:0] disch_ohm200_o,
   output logic [NUM_RAILS-1:0] disch_ohm500_o,
   // Output three configuration and pin
   input wire logic [1:0] out3_mode_i,
   input wire logic [NUM_RAILS-1:0] out3_rail_mask_i,
   input wire logic out3_term_use_i,
   input wire logic out3_host_level_i,
   input wire logic out3_shift_in_i,
   output logic general_output_three_o,
   output logic termination_regulator_en_o
);
   // Elaboration checks
   if (NUM_RAILS != `RDPG_NUM_RAILS)
      $error("rdpg_regs: register layout serves exactly seven rails");
   if (CNT_W > 31)
      $error("rdpg_regs: counter width above 31 not supported");
   if (DLY0_CYC < 1 || DLY7_CYC >= (1 << CNT_W) || DLY6_CYC >= (1 << CNT_W))
      $error("rdpg_regs: delay counts out of counter range");

   localparam int SW = NUM_RAILS + 1;

   // Discharge selection storage
   logic [`RDPG_FLD_W-1:0] sel_reg [NUM_RAILS];
   logic [`RDPG_FLD_W-1:0] sel_next [NUM_RAILS];
   logic [NUM_RAILS-1:0] ohm100_next;
   logic [NUM_RAILS-1:0] ohm200_next;
   logic [NUM_RAILS-1:0] ohm500_next;
   logic [NUM_RAILS-1:0] ohm100_reg;
   logic [NUM_RAILS-1:0] ohm200_reg;
   logic [NUM_RAILS-1:0] ohm500_reg;

   // Address decode
   wire logic hit_disch2 = reg_addr_i == `RDPG_OFS_DISCH2;
   wire logic hit_disch3 = reg_addr_i == `RDPG_OFS_DISCH3;
   wire logic hit_pgdly = reg_addr_i == `RDPG_OFS_PGDLY;
   wire logic wr_disch2 = reg_wr_i & hit_disch2;
   wire logic wr_disch3 = reg_wr_i & hit_disch3;
   wire logic wr_pgdly = reg_wr_i & hit_pgdly;

   for (genvar k = 0; k < NUM_RAILS; k++)
   begin : g_rail
      localparam int POS = (k < `RDPG_DISCH2_RAILS) ? k * `RDPG_FLD_W :
         (k - `RDPG_DISCH2_RAILS) * `RDPG_FLD_W;
      wire logic wr_hit = (k < `RDPG_DISCH2_RAILS) ? wr_disch2 : wr_disch3;
      wire logic [`RDPG_FLD_W-1:0] wr_field = reg_wdata_i[POS +: `RDPG_FLD_W];
      // An enabled rail wins over a write in the same cycle
      assign sel_next[k] = rail_enable_i[k] ? DISCH_NONE :
         (wr_hit ? wr_field : sel_reg[k]);
      // Enabled rail presents no discharge from the same edge that clears the stored field
      assign ohm100_next[k] = !rail_enable_i[k] && sel_next[k] == DISCH_R100;
      assign ohm200_next[k] = !rail_enable_i[k] && sel_next[k] == DISCH_R200;
      assign ohm500_next[k] = !rail_enable_i[k] && sel_next[k] == DISCH_R500;

      always_ff @(posedge core_clk_i)
      begin
         if (srst_i)
            sel_reg[k] <= `RDPG_SEL_RST;
         else
            sel_reg[k] <= sel_next[k];
      end
   end

   // Power-good delay field
   logic [`RDPG_DLY_W-1:0] dly_reg;
   wire logic [`RDPG_DLY_W-1:0] dly_next = wr_pgdly ? reg_wdata_i[`RDPG_DLY_W-1:0] : dly_reg;

   // Read path
   wire logic [7:0] rd_disch2 = {sel_reg[3], sel_reg[2], sel_reg[1], sel_reg[0]};
   wire logic [7:0] rd_disch3 = {`RDPG_DISCH3_PAD, sel_reg[6], sel_reg[5], sel_reg[4]};
   wire logic [7:0] rd_pgdly = {`RDPG_PGDLY_PAD, dly_reg};
   wire logic [7:0] rd_word = hit_disch2 ? rd_disch2 :
      hit_disch3 ? rd_disch3 :
      hit_pgdly ? rd_pgdly : `RDPG_UNMAPPED;
   logic [7:0] rdata_reg;
   wire logic [7:0] rdata_next = reg_rd_i ? rd_word : rdata_reg;

   // Pin inputs: three stages, a change is taken once stages two and three agree
   logic [SW-1:0] sync1_reg;
   logic [SW-1:0] sync2_reg;
   logic [SW-1:0] sync3_reg;
   logic [SW-1:0] filt_reg;
   wire logic [SW-1:0] agree = ~(sync2_reg ^ sync3_reg);
   wire logic [SW-1:0] filt_next = (agree & sync3_reg) | (~agree & filt_reg);
   wire logic [NUM_RAILS-1:0] in_reg_f = filt_reg[NUM_RAILS-1:0];
   wire logic shift_in_f = filt_reg[NUM_RAILS];

   // All grouped rails in regulation; an empty group never qualifies
   wire logic rails_good = (|out3_rail_mask_i) &
      (&(in_reg_f | ~out3_rail_mask_i));

   // Delay table
   function automatic logic [CNT_W-1:0] dly_cycles(input logic [`RDPG_DLY_W-1:0] code);
      logic [CNT_W-1:0] cyc;
      cyc = CNT_W'(DLY0_CYC);
      unique case (code)
         3'h0: cyc = CNT_W'(DLY0_CYC);
         3'h1: cyc = CNT_W'(DLY1_CYC);
         3'h2: cyc = CNT_W'(DLY2_CYC);
         3'h3: cyc = CNT_W'(DLY3_CYC);
         3'h4: cyc = CNT_W'(DLY4_CYC);
         3'h5: cyc = CNT_W'(DLY5_CYC);
         3'h6: cyc = CNT_W'(DLY6_CYC);
         3'h7: cyc = CNT_W'(DLY7_CYC);
      endcase
      return cyc;
   endfunction

   wire logic [CNT_W-1:0] dly_limit = dly_cycles(dly_reg);

   // Output three role selection
   wire logic mode_pg = out3_mode_i == OUT3_POWER_GOOD;
   wire logic mode_ls = out3_mode_i == OUT3_LEVEL_SHIFT;
   wire logic mode_host = out3_mode_i == OUT3_HOST;
   // Level shifter passes its input only once the grouped rails are good
   wire logic trigger = mode_pg ? rails_good :
      mode_ls ? (rails_good & shift_in_f) :
      (mode_host & out3_term_use_i & out3_host_level_i);
   logic delay_done;

   rdpg_delay_timer #(
      .CNT_W(CNT_W)
   ) u_timer (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .start_i(trigger),
      .limit_i(dly_limit),
      .done_o(delay_done)
   );

   // Host role drives the pin directly; the delay only gates termination enable
   wire logic out3_next = mode_host ? out3_host_level_i : delay_done;
   wire logic term_next = out3_term_use_i & delay_done;
   logic out3_reg;
   logic term_reg;

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         dly_reg <= `RDPG_DLY_RST;
         rdata_reg <= `RDPG_RDATA_RST;
         ohm100_reg <= '0;
         ohm200_reg <= '0;
         ohm500_reg <= '0;
      end
      else
      begin
         dly_reg <= dly_next;
         rdata_reg <= rdata_next;
         ohm100_reg <= ohm100_next;
         ohm200_reg <= ohm200_next;
         ohm500_reg <= ohm500_next;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
         filt_reg <= '0;
      end
      else
      begin
         sync1_reg <= {out3_shift_in_i, rail_in_reg_i};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         filt_reg <= filt_next;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         out3_reg <= 1'b0;
         term_reg <= 1'b0;
      end
      else
      begin
         out3_reg <= out3_next;
         term_reg <= term_next;
      end
   end

   assign reg_rdata_o = rdata_reg;
   assign disch_ohm100_o = ohm100_reg;
   assign disch_ohm200_o = ohm200_reg;
   assign disch_ohm500_o = ohm500_reg;
   assign general_output_three_o = out3_reg;
   assign termination_regulator_en_o = term_reg;
endmodule

// >>> tb/rdpg_host_model.sv
module rdpg_host_model
(
   input wire logic core_clk_i,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] exp_q[$];
   initial
   begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
   end
   // Idle lines show the inverse so a stale address or data is never mistaken for valid
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= wr;
      reg_rd_o <= !wr;
      @(posedge core_clk_i);
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
      @(posedge core_clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      access(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      access(1'b0, a, ~e);
   endtask
endmodule

// >>> tb/rdpg_regs_properties.sv
module rdpg_regs_properties
#(
   parameter int NUM_RAILS = 7
)
(
   // Clock, reset and register port
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   // Rails and discharge
   input wire logic [NUM_RAILS-1:0] rail_enable_i,
   input wire logic [NUM_RAILS-1:0] rail_in_reg_i,
   input wire logic [NUM_RAILS-1:0] disch_ohm100_o,
   input wire logic [NUM_RAILS-1:0] disch_ohm200_o,
   input wire logic [NUM_RAILS-1:0] disch_ohm500_o,
   // Output three
   input wire logic [1:0] out3_mode_i,
   input wire logic [NUM_RAILS-1:0] out3_rail_mask_i,
   input wire logic out3_term_use_i,
   input wire logic out3_host_level_i,
   input wire logic out3_shift_in_i,
   input wire logic general_output_three_o,
   input wire logic termination_regulator_en_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   wire [NUM_RAILS-1:0] any_disch = disch_ohm100_o | disch_ohm200_o | disch_ohm500_o;
   wire rails_bad = (rail_in_reg_i & out3_rail_mask_i) != out3_rail_mask_i;

   a_enabled_no_disch: assert property (!(|(any_disch & $past(rail_enable_i))))
      else $error("discharge active on an enabled rail");
   a_disch_one_hot: assert property (((disch_ohm100_o & disch_ohm200_o)
      | (disch_ohm100_o & disch_ohm500_o) | (disch_ohm200_o & disch_ohm500_o)) == '0)
      else $error("more than one discharge resistance on a rail");
   a_unmapped_zero: assert property (reg_rd_i && (reg_addr_i < 8'h41 || reg_addr_i > 8'h43)
      |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
   a_third_pad_zero: assert property (reg_rd_i && reg_addr_i == 8'h42
      |=> reg_rdata_o[7:6] == 2'h0) else $error("reserved discharge bits not zero");
   a_delay_pad_zero: assert property (reg_rd_i && reg_addr_i == 8'h43
      |=> reg_rdata_o[7:3] == 5'h00) else $error("reserved delay bits not zero");
   a_second_readback: assert property (reg_wr_i && reg_addr_i == 8'h41 && rail_enable_i[3:0] == 4'h0
      ##1 !reg_wr_i && rail_enable_i[3:0] == 4'h0 ##1 reg_rd_i && !reg_wr_i && reg_addr_i == 8'h41
      |=> reg_rdata_o == $past(reg_wdata_i, 3)) else $error("written value not read back");
   a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data changed without a read");
   a_pg_waits_rails: assert property ((out3_mode_i == 2'h0
      && (rails_bad || out3_rail_mask_i == '0))[*8] |-> !general_output_three_o)
      else $error("power good asserted before rails regulate");
   a_host_follows: assert property ((out3_mode_i == 2'h2)[*2]
      |-> general_output_three_o == $past(out3_host_level_i)) else $error("host level not followed");
   a_mode3_low: assert property ((out3_mode_i == 2'h3)[*3] |-> !general_output_three_o)
      else $error("output three high in unused mode");
   a_term_needs_use: assert property ((!out3_term_use_i)[*2] |-> !termination_regulator_en_o)
      else $error("termination enable without use");
endmodule

// >>> tb/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NUM_RAILS = 7;
   logic core_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic reg_wr_i, reg_rd_i, rd_d = 1'b0;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
   logic [6:0] rail_enable_i = '0, rail_in_reg_i = '0, out3_rail_mask_i = '0, o100, o200, o500;
   logic [1:0] out3_mode_i = 2'h0;
   logic out3_term_use_i = 1'b0, out3_host_level_i = 1'b0, out3_shift_in_i = 1'b0;
   logic out3_o, term_o;
   int err_count = 0, samples_checked = 0, cycles = 0, seed = 24;
   int dly[8] = '{5, 10, 20, 30, 40, 100, 150, 200};

   // A short unit keeps the longest delay code within a few hundred cycles
   rdpg_regs #(.DLY_UNIT_CYC(5)) u_dut (.core_clk_i(core_clk_i),
      .srst_i(srst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .rail_enable_i(rail_enable_i),
      .rail_in_reg_i(rail_in_reg_i), .disch_ohm100_o(o100), .disch_ohm200_o(o200),
      .disch_ohm500_o(o500), .out3_mode_i(out3_mode_i), .out3_rail_mask_i(out3_rail_mask_i),
      .out3_term_use_i(out3_term_use_i), .out3_host_level_i(out3_host_level_i),
      .out3_shift_in_i(out3_shift_in_i), .general_output_three_o(out3_o),
      .termination_regulator_en_o(term_o));
   rdpg_host_model u_host (.core_clk_i(core_clk_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
      .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));

   initial
      forever #5 core_clk_i = ~core_clk_i;

   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Read data lands one edge after the strobe, so it is picked up at the next falling edge
   always @(posedge core_clk_i)
   begin
      rd_d <= reg_rd_i;
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         err_count++;
         close_out();
      end
   end
   always @(negedge core_clk_i)
      if (rd_d === 1'b1)
         check("rdata", reg_rdata_o, u_host.exp_q.pop_front());

   task automatic wait_out3(input int lo, input int hi);
      int k;
      k = 0;
      @(negedge core_clk_i);
      while (out3_o !== 1'b1 && k <= hi)
      begin
         @(negedge core_clk_i);
         k++;
      end
      check("delay", 8'(k >= lo && k <= hi), 8'h01);
      @(posedge core_clk_i);
   endtask

   // Outputs are read at the falling edge, never in the step of the edge that launches them
   function automatic logic [7:0] probe(input string nm);
      case (nm)
         "ohm100": return 8'(o100);
         "ohm200": return 8'(o200);
         "ohm500": return 8'(o500);
         "disch": return 8'(o100 | o200 | o500);
         "term": return 8'(term_o);
         default: return 8'(out3_o);
      endcase
   endfunction

   task automatic look(input string nm, input logic [7:0] exp);
      @(negedge core_clk_i);
      check(nm, probe(nm), exp);
      @(posedge core_clk_i);
   endtask

   initial
   begin
      repeat (5) @(posedge core_clk_i);
      srst_i <= 1'b0;
      @(posedge core_clk_i);
      u_host.rd(8'h41, 8'h00);
      u_host.rd(8'h42, 8'h00);
      u_host.rd(8'h43, 8'h00);
      u_host.rd(8'h40, 8'h00);
      u_host.wr(8'h41, 8'hE4);
      u_host.rd(8'h41, 8'hE4);
      u_host.wr(8'h42, 8'hFF);
      u_host.rd(8'h42, 8'h3F);
      u_host.wr(8'h42, 8'h39);
      look("ohm100", 8'h12);
      look("ohm200", 8'h24);
      look("ohm500", 8'h48);
      u_host.wr(8'h43, 8'hFF);
      u_host.rd(8'h43, 8'h07);
      for (int i = 0; i < 4; i++)
      begin
         d = 8'($random(seed));
         u_host.wr(8'h41, d);
         u_host.rd(8'h41, d);
      end
      rail_enable_i <= 7'h7F;
      u_host.wr(8'h41, 8'hFF);
      look("disch", 8'h00);
      rail_enable_i <= 7'h00;
      u_host.rd(8'h41, 8'h00);
      u_host.rd(8'h42, 8'h00);
      out3_rail_mask_i <= 7'h41;
      for (int c = 0; c < 8; c++)
      begin
         rail_in_reg_i <= 7'h00;
         u_host.wr(8'h43, 8'(c));
         rail_in_reg_i <= 7'h01;
         repeat (12) @(posedge core_clk_i);
         look("early", 8'h00);
         rail_in_reg_i <= 7'h41;
         wait_out3(dly[c] + 2, dly[c] + 9);
      end
      u_host.wr(8'h43, 8'h00);
      out3_mode_i <= 2'h1;
      repeat (20) @(posedge core_clk_i);
      look("shift_low", 8'h00);
      out3_shift_in_i <= 1'b1;
      wait_out3(7, 14);
      out3_mode_i <= 2'h2;
      for (int i = 0; i < 4; i++)
      begin
         out3_host_level_i <= !out3_host_level_i;
         repeat (2) @(posedge core_clk_i);
         look("host", 8'(out3_host_level_i));
      end
      look("term", 8'h00);
      // Termination use: the enable waits out the delay while the pin follows the host
      out3_term_use_i <= 1'b1;
      out3_host_level_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      look("term", 8'h00);
      repeat (4) @(posedge core_clk_i);
      look("term", 8'h01);
      look("host", 8'h01);
      out3_term_use_i <= 1'b0;
      out3_mode_i <= 2'h3;
      repeat (4) @(posedge core_clk_i);
      look("mode3", 8'h00);
      close_out();
   end
endmodule

bind rdpg_regs rdpg_regs_properties #(.NUM_RAILS(NUM_RAILS)) u_props (.core_clk_i(core_clk_i),
   .srst_i(srst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .rail_enable_i(rail_enable_i),
   .rail_in_reg_i(rail_in_reg_i), .disch_ohm100_o(disch_ohm100_o),
   .disch_ohm200_o(disch_ohm200_o), .disch_ohm500_o(disch_ohm500_o),
   .out3_mode_i(out3_mode_i), .out3_rail_mask_i(out3_rail_mask_i),
   .out3_term_use_i(out3_term_use_i), .out3_host_level_i(out3_host_level_i),
   .out3_shift_in_i(out3_shift_in_i), .general_output_three_o(general_output_three_o),
   .termination_regulator_en_o(termination_regulator_en_o));
